// ===== dc_seq_consts.vh
/*
 constants for the dc test macro sequencer: register offsets, field positions,
 opcodes, test codes and timing counts. assumes a 200 MHz core clock.
*/
`ifndef DC_SEQ_CONSTS_VH
`define DC_SEQ_CONSTS_VH
// ************
// registers
// ************
`define ADDR_CMD 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_IFACE 4'h2
`define ADDR_DELAY 4'h3
`define ADDR_SETUP 4'h4
`define ADDR_FORCE 4'h5
`define ADDR_RESULT 4'h6
// ************
// commands, low nibble of cmd register
// ************
`define OP_RESET 4'h1
`define OP_DELAY 4'h2
`define OP_WAIT 4'h3
`define OP_CLRFAIL 4'h4
`define OP_SELTEST 4'h5
`define OP_MEASNUM 4'h6
`define OP_MEASPIN 4'h7
`define OP_RELAYEN 4'h8
`define OP_RELAYDIS 4'h9
`define OP_CONNECT 4'ha
`define OP_DISCONNECT 4'hb
// ************
// fields and codes
// ************
`define FAIL_FCT 0
`define FAIL_DCT 1
`define FAIL_TRIP 2
`define IFACE_W 15
`define TEST_MAX 4'ha
`define TEST_NONE 4'h8
// ************
// timing
// ************
`define RESET_TIME_NS 5370
`define CLK_NS 5
`define RESET_CYC ((`RESET_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define STEP_CYC 16'h0004
`endif

// ===== dc_test_macro_sequencer.v
/*
 dc test macro sequencer: command port, delay and wait control, fail flags,
 external interface register and the stored test macro engine.
 assumes a classic wishbone master on the core clock and a measurement unit
 that accepts one step per stepValid pulse and returns measPass with it.
*/
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "dc_seq_consts.vh"
module dc_test_macro_sequencer #(
    parameter PIN_W = 8,
    parameter [31:0] RESET_CYCLES = `RESET_CYC
) (
    input wire core_clk,
    input wire reset,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire measPass,
    input wire [15:0] measData,
    output reg stepValid,
    output reg [2:0] stepKind,
    output reg [PIN_W-1:0] stepPin,
    output reg stepIsCurrent,
    output reg [11:0] stepValue,
    output reg [1:0] stepRange,
    output reg relayEnable,
    output reg condDisconnect,
    output reg [`IFACE_W-1:0] externalIface,
    output reg busy
);
// step kinds driven to the measurement unit
localparam [2:0] K_CONNECT = 3'h0, K_RELAY = 3'h1, K_FORCE = 3'h2, K_MEASURE = 3'h3;
localparam [2:0] K_DISCON = 3'h4, K_COMPARE = 3'h5, K_RESET = 3'h6;
localparam [3:0] S_IDLE = 4'h0, S_CONN = 4'h1, S_RELOFF = 4'h2, S_FORCE = 4'h3;
localparam [3:0] S_MEAS = 4'h4, S_ZERO = 4'h5, S_RELON = 4'h6, S_REST = 4'h7;
localparam [3:0] S_SETTLE = 4'h8, S_FORCE2 = 4'h9, S_DISC = 4'ha, S_WAIT = 4'hb;
// ************
// registers
// ************
reg [3:0] state_q;
reg [31:0] timer_q;
reg [15:0] delay_q;
reg [2:0] fail_q;
reg [3:0] test_q;
reg testValid_q;
reg [PIN_W-1:0] restPin_q;
reg [PIN_W-1:0] curPin_q;
reg [PIN_W-1:0] tgtPin_q;
reg connected_q;
reg forceCur_q;
reg [11:0] forceVal_q;
reg [1:0] forceRng_q;
reg [11:0] altVal_q;
reg [15:0] result_q;
reg waitPend_q;
reg cmdErr_q;
wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire wbWr = wbReq && wb_we_i;
wire [3:0] op = wb_dat_i[3:0];
wire [PIN_W-1:0] opPin = wb_dat_i[PIN_W+7:8];
wire idle = (state_q == S_IDLE) && (timer_q == 32'h0);
wire isCmd = wbWr && (wb_adr_i == `ADDR_CMD) && wb_sel_i[0];
// accepted only when test code 1..10 except 8
wire testOk = (wb_dat_i[19:16] != 4'h0) && (wb_dat_i[19:16] <= `TEST_MAX) &&
    (wb_dat_i[19:16] != `TEST_NONE);
wire [31:0] delayCyc = {16'h0000, delay_q};
wire [31:0] resetCyc = (delayCyc > RESET_CYCLES) ? delayCyc : RESET_CYCLES;
// ************
// wishbone read side
// ************
always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0;
    end else begin
        wb_ack_o <= wbReq;
        if (wbReq && !wb_we_i) begin
            case (wb_adr_i)
                `ADDR_STATUS: wb_dat_o <= {21'h0, cmdErr_q, testValid_q, test_q, connected_q,
                    fail_q, busy};
                `ADDR_IFACE: wb_dat_o <= {17'h0, externalIface};
                `ADDR_DELAY: wb_dat_o <= {16'h0, delay_q};
                `ADDR_SETUP: wb_dat_o <= {forceCur_q, 1'b0, forceRng_q, 12'h0, 8'h0, restPin_q};
                `ADDR_FORCE: wb_dat_o <= {4'h0, altVal_q, 4'h0, forceVal_q};
                `ADDR_RESULT: wb_dat_o <= {16'h0, result_q};
                default: wb_dat_o <= 32'h0;
            endcase
        end
    end
end
// ************
// sequencer
// ************
always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        state_q <= S_IDLE;
        timer_q <= 32'h0;
        delay_q <= 16'h0;
        fail_q <= 3'h0;
        test_q <= 4'h0;
        testValid_q <= 1'b0;
        restPin_q <= {PIN_W{1'b0}};
        curPin_q <= {PIN_W{1'b0}};
        tgtPin_q <= {PIN_W{1'b0}};
        connected_q <= 1'b0;
        forceCur_q <= 1'b0;
        forceVal_q <= 12'h0;
        forceRng_q <= 2'h0;
        altVal_q <= 12'h0;
        result_q <= 16'h0;
        waitPend_q <= 1'b0;
        cmdErr_q <= 1'b0;
        stepValid <= 1'b0;
        stepKind <= K_RESET;
        stepPin <= {PIN_W{1'b0}};
        stepIsCurrent <= 1'b0;
        stepValue <= 12'h0;
        stepRange <= 2'h0;
        relayEnable <= 1'b0;
        condDisconnect <= 1'b0;
        externalIface <= {`IFACE_W{1'b0}};
        busy <= 1'b0;
    end else begin
        stepValid <= 1'b0;
        if (timer_q != 32'h0)
            timer_q <= timer_q - 32'h1;
        // connect drops the conditioner only when relay mode is disabled
        condDisconnect <= connected_q && !relayEnable;
        busy <= (state_q != S_IDLE) || (timer_q != 32'h0) || waitPend_q;
        if (waitPend_q && idle)
            waitPend_q <= 1'b0;
        if (wbWr && wb_adr_i == `ADDR_IFACE) begin
            if (wb_sel_i[0])
                externalIface[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                externalIface[14:8] <= wb_dat_i[14:8];
        end
        if (wbWr && wb_adr_i == `ADDR_DELAY) begin
            if (wb_sel_i[0])
                delay_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                delay_q[15:8] <= wb_dat_i[15:8];
        end
        // mode and value stay fixed while a macro runs
        if (wbWr && wb_adr_i == `ADDR_FORCE && state_q == S_IDLE) begin
            forceCur_q <= wb_dat_i[31];
            forceRng_q <= wb_dat_i[29:28];
            forceVal_q <= wb_dat_i[11:0];
            altVal_q <= wb_dat_i[27:16];
        end
        // commands during a macro or pending wait are refused and flagged
        if (isCmd && (state_q != S_IDLE || waitPend_q)) begin
            cmdErr_q <= 1'b1;
        end else if (isCmd) begin
            cmdErr_q <= 1'b0;
            case (op)
                `OP_RESET: begin
                    fail_q <= 3'h0;
                    testValid_q <= 1'b0;
                    test_q <= 4'h0;
                    connected_q <= 1'b0;
                    curPin_q <= {PIN_W{1'b0}};
                    relayEnable <= 1'b0;
                    forceCur_q <= 1'b1;
                    forceVal_q <= 12'h0;
                    forceRng_q <= 2'h0;
                    externalIface <= {`IFACE_W{1'b0}};
                    stepValid <= 1'b1;
                    stepKind <= K_RESET;
                    timer_q <= resetCyc;
                end
                `OP_DELAY: timer_q <= delayCyc;
                `OP_WAIT: waitPend_q <= !idle;
                `OP_CLRFAIL: fail_q <= fail_q & ~wb_dat_i[10:8];
                `OP_SELTEST: begin
                    if (testOk) begin
                        test_q <= wb_dat_i[19:16];
                        testValid_q <= 1'b1;
                        restPin_q <= connected_q ? curPin_q : {PIN_W{1'b0}};
                    end else begin
                        cmdErr_q <= 1'b1;
                    end
                end
                `OP_MEASNUM: begin
                    if (testValid_q) begin
                        tgtPin_q <= opPin;
                        state_q <= S_CONN;
                    end else begin
                        cmdErr_q <= 1'b1;
                    end
                end
                `OP_MEASPIN: begin
                    stepValid <= 1'b1;
                    stepKind <= K_COMPARE;
                    stepPin <= curPin_q;
                    timer_q <= {16'h0, `STEP_CYC};
                    if (!measPass)
                        fail_q[`FAIL_DCT] <= 1'b1;
                end
                `OP_RELAYEN: begin
                    relayEnable <= 1'b1;
                    condDisconnect <= 1'b0;
                end
                `OP_RELAYDIS: relayEnable <= 1'b0;
                `OP_CONNECT: begin
                    curPin_q <= opPin;
                    connected_q <= 1'b1;
                    stepValid <= 1'b1;
                    stepKind <= K_CONNECT;
                    stepPin <= opPin;
                    timer_q <= {16'h0, `STEP_CYC};
                end
                `OP_DISCONNECT: begin
                    curPin_q <= {PIN_W{1'b0}};
                    connected_q <= 1'b0;
                    stepValid <= 1'b1;
                    stepKind <= K_DISCON;
                    timer_q <= {16'h0, `STEP_CYC};
                end
                default: cmdErr_q <= 1'b1;
            endcase
        end
        // macro engine, one step per elapsed step time, except the settle state, which waits the delay and issues no step
        if (state_q != S_IDLE && timer_q == 32'h0) begin
            stepPin <= tgtPin_q;
            stepIsCurrent <= forceCur_q;
            stepRange <= forceRng_q;
            stepValue <= forceVal_q;
            timer_q <= {16'h0, `STEP_CYC};
            stepValid <= 1'b1;
            case (state_q)
                S_CONN: begin
                    stepKind <= K_CONNECT;
                    curPin_q <= tgtPin_q;
                    connected_q <= 1'b1;
                    if (test_q == 4'h3 || test_q == 4'h4) begin
                        state_q <= S_SETTLE;
                    end else if (forceCur_q) begin
                        relayEnable <= 1'b1;
                        condDisconnect <= 1'b0;
                        state_q <= S_RELOFF;
                    end else begin
                        state_q <= S_FORCE;
                    end
                end
                S_RELOFF: begin
                    stepKind <= K_RELAY;
                    relayEnable <= 1'b0;
                    state_q <= S_FORCE;
                end
                S_FORCE: begin
                    stepKind <= K_FORCE;
                    state_q <= S_MEAS;
                end
                S_SETTLE: begin
                    stepValid <= 1'b0;
                    timer_q <= delayCyc;
                    state_q <= S_MEAS;
                end
                S_MEAS: begin
                    stepKind <= K_MEASURE;
                    result_q <= measData;
                    if (!measPass)
                        fail_q[`FAIL_DCT] <= 1'b1;
                    if (test_q == 4'h3 || test_q == 4'h4)
                        state_q <= S_IDLE;
                    else if (forceCur_q)
                        state_q <= S_ZERO;
                    else
                        state_q <= S_FORCE2;
                end
                S_ZERO: begin
                    stepKind <= K_FORCE;
                    stepValue <= 12'h0;
                    state_q <= S_RELON;
                end
                S_RELON: begin
                    stepKind <= K_RELAY;
                    stepValue <= 12'h0;
                    relayEnable <= 1'b1;
                    condDisconnect <= 1'b0;
                    state_q <= (test_q == 4'h1 || test_q == 4'h2) ? S_REST : S_IDLE;
                end
                S_REST: begin
                    stepKind <= K_CONNECT;
                    stepValue <= 12'h0;
                    stepPin <= restPin_q;
                    curPin_q <= restPin_q;
                    state_q <= S_IDLE;
                end
                S_FORCE2: begin
                    stepKind <= K_FORCE;
                    stepValue <= altVal_q;
                    state_q <= S_DISC;
                end
                S_DISC: begin
                    stepKind <= K_DISCON;
                    connected_q <= 1'b0;
                    curPin_q <= {PIN_W{1'b0}};
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
end
endmodule // dc_test_macro_sequencer

// ===== dc_seq_sva.sv
/* port checker for the macro sequencer.
 bound to every sequencer instance; sees its ports only. */
`timescale 1ns/1ps
`include "dc_seq_consts.vh"
module dc_seq_sva #(
    parameter PIN_W = 8,
    parameter [31:0] RESET_CYCLES = `RESET_CYC
) (
    input wire core_clk,
    input wire reset,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire measPass,
    input wire [15:0] measData,
    input wire stepValid,
    input wire [2:0] stepKind,
    input wire [PIN_W-1:0] stepPin,
    input wire stepIsCurrent,
    input wire [11:0] stepValue,
    input wire [1:0] stepRange,
    input wire relayEnable,
    input wire condDisconnect,
    input wire [`IFACE_W-1:0] externalIface,
    input wire busy
);
    // ************
    // helpers
    // ************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    wire done = wb_cyc_i && wb_stb_i && wb_ack_o;
    wire cmdDone = done && wb_we_i && wb_adr_i == `ADDR_CMD;
    wire ifDone = done && wb_adr_i == `ADDR_IFACE;
    wire [3:0] opNow = wb_dat_i[3:0];
    wire [14:0] ifData = wb_dat_i[14:0];
    reg lastReset_q;
    reg [31:0] busyCnt_q;
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lastReset_q <= 1'b0;
            busyCnt_q <= 32'h0;
        end else begin
            if (cmdDone)
                lastReset_q <= opNow == `OP_RESET;
            busyCnt_q <= busy ? busyCnt_q + 32'h1 : 32'h0;
        end
    end
    // ************
    // assertions
    // ************
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    iface_store_a: assert property (ifDone && wb_we_i && wb_sel_i[1:0] == 2'b11
        |=> externalIface == $past(ifData)) else $error("iface write lost");
    iface_quiet_a: assert property (ifDone && !busy |=> !busy)
        else $error("iface access made busy");
    reset_busy_a: assert property (cmdDone && opNow == `OP_RESET |-> ##[1:2] busy)
        else $error("no busy after reset");
    reset_long_a: assert property ($fell(busy) && lastReset_q |-> busyCnt_q >= RESET_CYCLES)
        else $error("reset busy too short");
    clear_quiet_a: assert property (cmdDone && opNow == `OP_CLRFAIL && !busy |=> !busy)
        else $error("clear fail made busy");
    macro_busy_a: assert property (stepValid && stepKind == 3'd3 |-> busy)
        else $error("measure step while idle");
    zero_after_a: assert property (stepValid && stepKind == 3'd3 && stepIsCurrent
        |-> ##[1:6] (stepValid && stepKind == 3'd2 && stepValue == 12'h000))
        else $error("no zero force after measure");
    relay_clamp_a: assert property (condDisconnect |-> !relayEnable)
        else $error("conditioner dropped with relay on");
    cover property (stepValid && stepKind == 3'd3);
    cover property ($fell(busy) && lastReset_q);
    cover property (condDisconnect);
endmodule // dc_seq_sva
bind dc_test_macro_sequencer dc_seq_sva #(.PIN_W(PIN_W), .RESET_CYCLES(RESET_CYCLES)) chk_u (
    .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .measPass(measPass), .measData(measData),
    .stepValid(stepValid), .stepKind(stepKind), .stepPin(stepPin),
    .stepIsCurrent(stepIsCurrent), .stepValue(stepValue), .stepRange(stepRange),
    .relayEnable(relayEnable), .condDisconnect(condDisconnect),
    .externalIface(externalIface), .busy(busy));

// ===== meas_unit_model.sv
/* measurement unit stand-in answering measure and compare steps.
 assumes the sequencer step outputs on the core clock. */
`timescale 1ns/1ps
module meas_unit_model (
    input wire core_clk,
    input wire stepValid,
    input wire [2:0] stepKind,
    input wire passWant,
    input wire [15:0] level,
    output wire measPass,
    output wire [15:0] measData
);
    // ************
    // level answer, junk while relays or connections settle
    // ************
    reg [1:0] hold_q = 2'h0;
    reg junk_q = 1'b0;
    wire sw = stepValid && (stepKind == 3'd0 || stepKind == 3'd1 || stepKind == 3'd4);
    wire live = !sw && hold_q == 2'h0;
    assign measPass = live ? passWant : junk_q;
    assign measData = live ? level : {16{junk_q}};
    always @(posedge core_clk) begin
        junk_q <= ~junk_q;
        hold_q <= sw ? 2'h2 : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);
    end
endmodule // meas_unit_model

// ===== test_dc_test_macro_sequencer.sv
/* bench for the macro sequencer: bus tasks and one task per scenario.
 assumes the sequencer, its bound checker and the measurement stand-in. */
`timescale 1ns/1ps
`include "dc_seq_consts.vh"
module test_dc_test_macro_sequencer;
    // ************
    // setup
    // ************
    localparam RC = 20;
    reg core_clk = 1'b0;
    reg reset = 1'b1;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [3:0] adr = 4'h0;
    reg [31:0] wdat = 32'h0;
    reg passWant = 1'b1;
    reg [15:0] level = 16'h0;
    wire [31:0] rdat;
    wire ack, measPass, stepValid, relayEnable, condDisconnect, busy;
    wire [15:0] measData;
    wire [2:0] stepKind;
    wire [14:0] externalIface;
    integer fail_count = 0;
    integer checks_done = 0;
    integer n;
    reg [31:0] rd;
    reg [2:0] kinds[$];
    always #2.5 core_clk = ~core_clk;
    dc_test_macro_sequencer #(.PIN_W(8), .RESET_CYCLES(RC)) DUT (
        .core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .measPass(measPass), .measData(measData), .stepValid(stepValid),
        .stepKind(stepKind), .stepPin(), .stepIsCurrent(), .stepValue(), .stepRange(),
        .relayEnable(relayEnable), .condDisconnect(condDisconnect),
        .externalIface(externalIface), .busy(busy));
    meas_unit_model precision_meas_unit (.core_clk(core_clk), .stepValid(stepValid), .stepKind(stepKind),
        .passWant(passWant), .level(level), .measPass(measPass), .measData(measData));
    always @(posedge core_clk)
        if (stepValid)
            kinds.push_back(stepKind);
    task chk(input string what, input [31:0] seen, input [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task bus(input w, input [3:0] a, input [31:0] d);
        integer i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        i = 0;
        do begin
            @(posedge core_clk);
            i = i + 1;
        end while (ack !== 1'b1 && i < 40);
        if (i >= 40)
            fail_count = fail_count + 1;
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge core_clk);
    endtask
    task idle;
        n = 0;
        do begin
            @(posedge core_clk);
            n = n + 1;
        end while (busy !== 1'b0 && n < 3000);
        if (n >= 3000)
            fail_count = fail_count + 1;
    endtask
    // ************
    // scenarios
    // ************
    task s_iface;
        bus(1, `ADDR_IFACE, 32'h7fff);
        chk("iface all", externalIface, 15'h7fff);
        bus(1, `ADDR_IFACE, 32'h0123);
        bus(0, `ADDR_IFACE, 0);
        bus(1, `ADDR_IFACE, rd | 32'h40);
        bus(0, `ADDR_IFACE, 0);
        chk("iface merge", rd, 32'h0163);
        bus(0, 4'hf, 0);
        chk("unmapped", rd, 0);
    endtask
    task s_codes;
        integer c;
        for (c = 1; c <= 10; c = c + 1) begin
            bus(1, `ADDR_CMD, {12'h0, c[3:0], 12'h0, `OP_SELTEST});
            bus(0, `ADDR_STATUS, 0);
            if (c == 8)
                chk("code refused", rd[10], 1);
            else
                chk("code held", rd[9:5], {1'b1, c[3:0]});
        end
    endtask
    task s_clear;
        passWant <= 1'b0;
        bus(1, `ADDR_CMD, {16'h0, 8'h02, 4'h0, `OP_CONNECT});
        chk("cond drop", condDisconnect, 1);
        idle;
        bus(1, `ADDR_CMD, `OP_MEASPIN);
        idle;
        chk("compare step", kinds[$], 5);
        bus(0, `ADDR_STATUS, 0);
        chk("dc fail", rd[2], 1);
        bus(1, `ADDR_CMD, 32'h200 | `OP_CLRFAIL);
        chk("clear quiet", busy, 0);
        bus(0, `ADDR_STATUS, 0);
        chk("fails", rd[3:1], 0);
        passWant <= 1'b1;
    endtask
    task s_delay;
        bus(1, `ADDR_DELAY, 32'd30);
        bus(1, `ADDR_CMD, `OP_DELAY);
        chk("delay busy", busy, 1);
        bus(1, `ADDR_CMD, `OP_WAIT);
        bus(1, `ADDR_CMD, `OP_RELAYEN);
        chk("stalled", relayEnable, 0);
        idle;
        chk("delay long", n > 20, 1);
    endtask
    task s_macro(input [3:0] code, input cur);
        reg [31:0] res;
        integer i;
        reg [2:0] ex[$];
        if (cur)
            ex = '{0, 1, 2, 3, 2, 1, 0};
        else
            ex = '{0, 3};
        bus(1, `ADDR_CMD, cur ? `OP_RELAYEN : `OP_RELAYDIS);
        idle;
        bus(1, `ADDR_CMD, {16'h0, 8'h03, 4'h0, `OP_CONNECT});
        chk("cond", condDisconnect, !cur);
        idle;
        bus(1, `ADDR_FORCE, {cur, 3'h2, 16'h0, 12'h123});
        bus(1, `ADDR_CMD, {12'h0, code, 12'h0, `OP_SELTEST});
        bus(0, `ADDR_SETUP, 0);
        chk("setup", rd, {cur, 3'h2, 20'h0, 8'h03});
        bus(0, `ADDR_RESULT, 0);
        res = rd;
        kinds = {};
        level <= level + 16'h1111;
        bus(1, `ADDR_CMD, {16'h0, 8'h05, 4'h0, `OP_MEASNUM});
        chk("macro busy", busy, 1);
        idle;
        chk("steps", kinds.size(), ex.size());
        for (i = 0; i < ex.size(); i = i + 1)
            chk("step", kinds[i], ex[i]);
        bus(0, `ADDR_RESULT, 0);
        chk("macro result", rd, {16'h0, level});
        chk("relay end", relayEnable, cur);
    endtask
    task s_reset;
        bus(1, `ADDR_DELAY, 32'd5);
        bus(1, `ADDR_CMD, `OP_RESET);
        chk("reset busy", busy, 1);
        idle;
        chk("reset floor", n >= RC - 2, 1);
        bus(1, `ADDR_DELAY, 32'd60);
        bus(1, `ADDR_CMD, `OP_RESET);
        idle;
        chk("reset delay", n >= 57, 1);
        bus(0, `ADDR_STATUS, 0);
        chk("test cleared", rd[9], 0);
        chk("relay default", relayEnable, 0);
    endtask
    task wrap_up;
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #100000;
        fail_count = fail_count + 1;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        s_iface;
        s_codes;
        s_clear;
        s_delay;
        s_macro(4'h3, 1'b0);
        s_macro(4'h1, 1'b1);
        s_macro(4'h2, 1'b1);
        s_reset;
        wrap_up;
    end
endmodule // test_dc_test_macro_sequencer
